// File: hdl/serial_port_uart_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_UART_CFG_SVH
`define SERIAL_PORT_UART_CFG_SVH
`define SPU_CTRL_ADDR   8'h98
`define SPU_BUF_ADDR    8'h99
`define SPU_CTRL_RST    8'h00
`define SPU_BUF_RST     8'h00
`define SPU_MODE_HI     7
`define SPU_MODE_LO     6
`define SPU_MP_EN       5
`define SPU_RX_EN       4
`define SPU_TX_NINTH    3
`define SPU_RX_NINTH    2
`define SPU_TX_DONE     1
`define SPU_RX_DONE     0
`define SPU_SUB_MID     4'h7
`define SPU_SUB_LAST    4'hF
`define SPU_M0_LAST     3'h7
`define SPU_BITS_UART8  4'hA
`define SPU_BITS_UART9  4'hB
`define SPU_RX_LAST8    4'h8
`define SPU_RX_LAST9    4'h9
`endif

// File: hdl/serial_port_uart_pkg.sv
// Types shared by the serial port design
package serial_port_uart_pkg;
	typedef enum logic [1:0] {
		MODE_SHIFT  = 2'b00,
		MODE_UART8  = 2'b01,
		MODE_UART9F = 2'b10,
		MODE_UART9V = 2'b11
	} mode_t;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10
	} rx_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  rx_buf;
		logic [7:0]  rdata;
		logic        rxd_s1;
		logic        rxd_s2;
		logic        rxd_d;
		logic        tt_s1;
		logic        tt_s2;
		logic        tt_d;
		logic        rt_s1;
		logic        rt_s2;
		logic        rt_d;
		logic        div;
		logic        tx_busy;
		logic [10:0] tx_sh;
		logic [3:0]  tx_left;
		logic [3:0]  tx_sub;
		rx_state_t   rx_st;
		logic [9:0]  rx_sh;
		logic [3:0]  rx_cnt;
		logic [3:0]  rx_sub;
		logic        m0_busy;
		logic        m0_rx;
		logic        m0_ph;
		logic [2:0]  m0_cnt;
		logic [7:0]  m0_sh;
		logic        txd_low;
		logic        rxd_drive;
		logic        rxd_out;
	} core_state_t;
	typedef struct packed {
		logic rst_s1;
		logic rst_ok;
		logic tx_tog;
		logic rx_tog;
	} baud_state_t;
endpackage : serial_port_uart_pkg

// File: hdl/serial_port_uart.sv
// Serial port, full duplex in modes 1 to 3 and half duplex in shift mode, with control and buffer registers
//
// What this block does
// R1: In modes 1 to 3 transmit and receive paths are independent and run at the same time; shift mode does one at a time.
// R2: One received byte is held; a newer completed byte overwrites it.
// R3: Buffer address writes the transmit register, reads the separate receive register.
// R4: Control bits 7:6 select shift, 8-bit, 9-bit fixed or 9-bit variable mode.
// R5: Shift mode clocks at core clock divided by two.
// R6: Mode 2 bit rate is core clock over 32 or over 16.
// R7: baud_double low gives over 32, high gives over 16.
// R8: Mode 1 with multiproc_enable needs a valid stop bit to flag reception.
// R9: Modes 2 and 3 with multiproc_enable drop frames whose ninth bit is zero.
// R10: Serial data is accepted only while receive_enable is one, except that a shift-mode reception already started runs to its end.
// R11: Modes 2 and 3 send tx_ninth_bit as ninth data bit.
// R12: rx_ninth_bit takes received ninth bit, or stop bit in mode 1.
// R13: tx_done_flag sets after eighth bit in mode 0, else at stop start.
// R14: rx_done_flag sets after eighth bit in mode 0, else mid stop bit.
// R15: Shift mode moves data on rx_data_pin and drives shift clock on tx_pin.
// R16: Shift mode write sends eight bits, least significant first.
// R17: Shift mode reception starts only with receive_enable one and rx_done_flag zero.
// R18: Mode 1 frame is start zero, eight bits LSB first, stop one.
// R19: Modes 2 and 3 frame is start, eight data, ninth, stop: eleven bits.
// R20: Modes 1 and 3 use external transmit and receive ticks, sixteen per bit.
`timescale 1ns/1ns
`include "serial_port_uart_cfg.svh"
module serial_port_uart (
	// Core clock and reset
	input  wire logic                          i_mclk,
	input  wire logic                          i_rst_n,
	// Register port
	input  wire serial_port_uart_pkg::sfr_req_t i_sfr,
	output logic [7:0]                         o_sfr_rdata,
	// Rate select from the power control register
	input  wire logic                          i_baud_double,
	// Baud tick domain
	input  wire logic                          i_baud_clk,
	input  wire logic                          i_tx_baud_tick,
	input  wire logic                          i_rx_baud_tick,
	// Serial pins
	input  wire logic                          i_rx_data_pin,
	output logic                               o_rx_data_pin,
	output logic                               o_rx_data_pin_oe_n,
	output logic                               o_tx_pin
);
	serial_port_uart_pkg::core_state_t s;
	serial_port_uart_pkg::core_state_t n;
	serial_port_uart_pkg::baud_state_t b;
	serial_port_uart_pkg::baud_state_t bn;
	serial_port_uart_pkg::mode_t       mode;
	logic                              wr_buf;
	logic                              wr_ctrl;
	logic                              tx_tick;
	logic                              rx_tick;
	logic                              set_ti;
	logic                              set_ri;

	// Baud domain: reset synchroniser and tick toggles
	always_comb begin
		bn = b;
		bn.rst_s1 = i_rst_n;
		bn.rst_ok = b.rst_s1;
		if (!b.rst_ok) begin
			bn.tx_tog = 1'b0;
			bn.rx_tog = 1'b0;
		end else begin
			bn.tx_tog = b.tx_tog ^ i_tx_baud_tick; // [R20]
			bn.rx_tog = b.rx_tog ^ i_rx_baud_tick; // [R20]
		end
	end

	// Baud domain registers
	always_ff @(posedge i_baud_clk) begin
		b <= bn;
	end

	// Mode decode, register strobes and tick selection
	assign mode    = serial_port_uart_pkg::mode_t'(s.ctrl[`SPU_MODE_HI:`SPU_MODE_LO]); // [R4]
	assign wr_buf  = i_sfr.wr && (i_sfr.addr == `SPU_BUF_ADDR);
	assign wr_ctrl = i_sfr.wr && (i_sfr.addr == `SPU_CTRL_ADDR);
	assign tx_tick = (mode == serial_port_uart_pkg::MODE_UART9F) ? (i_baud_double | s.div) // [R6] [R7]
		: (s.tt_s2 ^ s.tt_d); // [R20]
	assign rx_tick = (mode == serial_port_uart_pkg::MODE_UART9F) ? (i_baud_double | s.div) // [R6] [R7]
		: (s.rt_s2 ^ s.rt_d); // [R20]

	// Core next-state logic
	always_comb begin
		n = s;
		set_ti = 1'b0;
		set_ri = 1'b0;
		n.rxd_s1 = i_rx_data_pin;
		n.rxd_s2 = s.rxd_s1;
		n.rxd_d  = s.rxd_s2;
		n.tt_s1  = b.tx_tog;
		n.tt_s2  = s.tt_s1;
		n.tt_d   = s.tt_s2;
		n.rt_s1  = b.rx_tog;
		n.rt_s2  = s.rt_s1;
		n.rt_d   = s.rt_s2;
		n.div    = ~s.div;
		if (wr_ctrl) begin
			n.ctrl = i_sfr.wdata;
		end
		if (i_sfr.rd) begin
			if (i_sfr.addr == `SPU_CTRL_ADDR) begin
				n.rdata = s.ctrl;
			end else if (i_sfr.addr == `SPU_BUF_ADDR) begin
				n.rdata = s.rx_buf; // [R3]
			end else begin
				n.rdata = 8'h00;
			end
		end
		// Shift register mode engine, half duplex on the data pin
		if (mode != serial_port_uart_pkg::MODE_SHIFT) begin
			n.m0_busy = 1'b0;
		end else if (wr_buf) begin
			n.m0_busy = 1'b1; // [R16]
			n.m0_rx   = 1'b0;
			n.m0_ph   = 1'b0;
			n.m0_cnt  = 3'h0;
			n.m0_sh   = i_sfr.wdata;
		end else if (!s.m0_busy && s.ctrl[`SPU_RX_EN] && !s.ctrl[`SPU_RX_DONE]) begin
			n.m0_busy = 1'b1; // [R17]
			n.m0_rx   = 1'b1;
			n.m0_ph   = 1'b0;
			n.m0_cnt  = 3'h0;
			n.m0_sh   = 8'h00;
		end else if (s.m0_busy) begin
			n.m0_ph = ~s.m0_ph; // [R5]
			if (s.m0_ph) begin
				n.m0_sh  = {(s.m0_rx & s.rxd_s2), s.m0_sh[7:1]}; // [R16]
				n.m0_cnt = s.m0_cnt + 3'h1;
				if (s.m0_cnt == `SPU_M0_LAST) begin
					n.m0_busy = 1'b0;
					if (s.m0_rx) begin
						set_ri   = 1'b1; // [R14]
						n.rx_buf = n.m0_sh; // [R2]
					end else begin
						set_ti = 1'b1; // [R13]
					end
				end
			end
		end
		// Asynchronous transmitter
		if (mode == serial_port_uart_pkg::MODE_SHIFT) begin
			n.tx_busy = 1'b0;
		end else if (wr_buf) begin
			n.tx_busy = 1'b1; // [R1]
			n.tx_sub  = 4'h0;
			if (mode == serial_port_uart_pkg::MODE_UART8) begin
				n.tx_sh   = {2'b11, i_sfr.wdata, 1'b0}; // [R18]
				n.tx_left = `SPU_BITS_UART8;
			end else begin
				n.tx_sh   = {1'b1, s.ctrl[`SPU_TX_NINTH], i_sfr.wdata, 1'b0}; // [R11] [R19]
				n.tx_left = `SPU_BITS_UART9;
			end
		end else if (s.tx_busy && tx_tick) begin
			n.tx_sub = s.tx_sub + 4'h1; // [R20]
			if (s.tx_sub == `SPU_SUB_LAST) begin
				n.tx_sh   = {1'b1, s.tx_sh[10:1]};
				n.tx_left = s.tx_left - 4'h1;
				if (s.tx_left == 4'h2) begin
					set_ti = 1'b1; // [R13]
				end
				if (s.tx_left == 4'h1) begin
					n.tx_busy = 1'b0;
				end
			end
		end
		// Asynchronous receiver
		if (!s.ctrl[`SPU_RX_EN] || mode == serial_port_uart_pkg::MODE_SHIFT) begin
			n.rx_st = serial_port_uart_pkg::RX_IDLE; // [R10]
		end else begin
			case (s.rx_st)
				serial_port_uart_pkg::RX_IDLE: begin
					if (s.rxd_d && !s.rxd_s2) begin
						n.rx_st  = serial_port_uart_pkg::RX_START;
						n.rx_sub = 4'h0;
						n.rx_cnt = 4'h0;
					end
				end
				serial_port_uart_pkg::RX_START: begin
					if (rx_tick) begin
						n.rx_sub = s.rx_sub + 4'h1;
						if (s.rx_sub == `SPU_SUB_MID && s.rxd_s2) begin
							n.rx_st = serial_port_uart_pkg::RX_IDLE;
						end else if (s.rx_sub == `SPU_SUB_LAST) begin
							n.rx_st = serial_port_uart_pkg::RX_BITS;
						end
					end
				end
				serial_port_uart_pkg::RX_BITS: begin
					if (rx_tick) begin
						n.rx_sub = s.rx_sub + 4'h1; // [R20]
						if (s.rx_sub == `SPU_SUB_MID) begin
							n.rx_sh  = {s.rxd_s2, s.rx_sh[9:1]};
							n.rx_cnt = s.rx_cnt + 4'h1;
							if (mode == serial_port_uart_pkg::MODE_UART8 && s.rx_cnt == `SPU_RX_LAST8) begin
								n.rx_st = serial_port_uart_pkg::RX_IDLE;
								if (!s.ctrl[`SPU_MP_EN] || n.rx_sh[9]) begin // [R8]
									set_ri   = 1'b1; // [R14]
									n.rx_buf = n.rx_sh[8:1]; // [R2]
									n.ctrl[`SPU_RX_NINTH] = n.rx_sh[9]; // [R12]
								end
							end else if (mode != serial_port_uart_pkg::MODE_UART8 && s.rx_cnt == `SPU_RX_LAST9) begin
								n.rx_st = serial_port_uart_pkg::RX_IDLE;
								if (!s.ctrl[`SPU_MP_EN] || n.rx_sh[8]) begin // [R9]
									set_ri   = 1'b1; // [R14]
									n.rx_buf = n.rx_sh[7:0]; // [R2]
									n.ctrl[`SPU_RX_NINTH] = n.rx_sh[8]; // [R12]
								end
							end
						end
					end
				end
				default: begin
					n.rx_st = serial_port_uart_pkg::RX_IDLE;
				end
			endcase
		end
		// Hardware set wins over a software clear in the same cycle
		n.ctrl[`SPU_TX_DONE] = n.ctrl[`SPU_TX_DONE] | set_ti;
		n.ctrl[`SPU_RX_DONE] = n.ctrl[`SPU_RX_DONE] | set_ri;
		// Pin drivers
		if (mode == serial_port_uart_pkg::MODE_SHIFT) begin
			n.txd_low = n.m0_busy && !n.m0_ph; // [R15]
		end else begin
			n.txd_low = n.tx_busy && !n.tx_sh[0];
		end
		n.rxd_drive = n.m0_busy && !n.m0_rx; // [R15]
		n.rxd_out   = n.m0_sh[0];
	end

	// Core registers
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s        <= '0;
			s.ctrl   <= `SPU_CTRL_RST;
			s.rx_buf <= `SPU_BUF_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from flip-flops
	assign o_sfr_rdata        = s.rdata;
	assign o_tx_pin           = ~s.txd_low;
	assign o_rx_data_pin      = s.rxd_out;
	assign o_rx_data_pin_oe_n = ~s.rxd_drive;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	// Checks
	buf_separate_a: assert property (wr_buf && !set_ri |=> $stable(s.rx_buf)) // [R3]
		else $error("buffer write changed receive value");
	shift_clock_a: assert property (s.m0_busy && !s.m0_ph && mode == serial_port_uart_pkg::MODE_SHIFT && !wr_buf
		|=> o_tx_pin ##1 (!s.m0_busy || !o_tx_pin || wr_buf)) // [R5]
		else $error("shift clock not at half core rate");
	shift_len_a: assert property (set_ti && mode == serial_port_uart_pkg::MODE_SHIFT
		|-> s.m0_cnt == 3'h7 && s.m0_ph && !s.m0_rx) // [R16]
		else $error("shift transmit ended early");
	start_bit_a: assert property (wr_buf && mode == serial_port_uart_pkg::MODE_UART8 |=> (!o_tx_pin)[*8]) // [R18]
		else $error("start bit missing");
	ti_stop_a: assert property ($rose(s.ctrl[`SPU_TX_DONE]) && mode != serial_port_uart_pkg::MODE_SHIFT
		&& !$past(wr_ctrl) |-> o_tx_pin) // [R13]
		else $error("transmit flag before stop bit");
	rx_enable_a: assert property (!s.ctrl[`SPU_RX_EN] |=> s.rx_st == serial_port_uart_pkg::RX_IDLE) // [R10]
		else $error("receiver active while disabled");
	mp_filter_a: assert property (set_ri && mode != serial_port_uart_pkg::MODE_SHIFT && s.ctrl[`SPU_MP_EN]
		|=> s.ctrl[`SPU_RX_NINTH]) // [R9]
		else $error("address filter let frame through");
	ri_set_a: assert property (set_ri |=> s.ctrl[`SPU_RX_DONE] && $past(n.rx_buf) == s.rx_buf) // [R14]
		else $error("receive flag lost");
	m0_rx_start_a: assert property ($rose(s.m0_busy) && s.m0_rx
		|-> $past(s.ctrl[`SPU_RX_EN] && !s.ctrl[`SPU_RX_DONE])) // [R17]
		else $error("shift receive started without enable");
	ninth_tx_a: assert property (wr_buf && (mode == serial_port_uart_pkg::MODE_UART9F
		|| mode == serial_port_uart_pkg::MODE_UART9V) |=> s.tx_sh[9] == $past(s.ctrl[`SPU_TX_NINTH])) // [R11]
		else $error("ninth bit not loaded");
	pin_release_a: assert property (mode != serial_port_uart_pkg::MODE_SHIFT |=> o_rx_data_pin_oe_n) // [R15]
		else $error("data pin driven outside shift mode");
	shift_tx_c: cover property (set_ti && mode == serial_port_uart_pkg::MODE_SHIFT);
	shift_rx_c: cover property (set_ri && mode == serial_port_uart_pkg::MODE_SHIFT);
	uart_rx_c: cover property (set_ri && mode == serial_port_uart_pkg::MODE_UART9V);
	full_duplex_c: cover property (s.tx_busy && s.rx_st == serial_port_uart_pkg::RX_BITS);
	// Further checks on flags, buffer overwrite, idle line level, rates and shift data pin drive
	tx_flag_set_a: assert property (set_ti |=> s.ctrl[`SPU_TX_DONE]) // [R13]
		else $error("transmit flag not set");
	rx_flag_hold_a: assert property (s.ctrl[`SPU_RX_DONE] && !wr_ctrl |=> s.ctrl[`SPU_RX_DONE]) // [R14]
		else $error("receive flag cleared by hardware");
	idle_line_a: assert property (!s.m0_busy && !s.tx_busy |-> o_tx_pin) // [R18]
		else $error("transmit line not idle high");
	rx_overwrite_a: assert property (set_ri && s.ctrl[`SPU_RX_DONE] |=> s.rx_buf == $past(n.rx_buf)) // [R2]
		else $error("unread byte not overwritten");
	mode2_rate_a: assert property (mode == serial_port_uart_pkg::MODE_UART9F && !i_baud_double && tx_tick
		|=> !tx_tick || mode != serial_port_uart_pkg::MODE_UART9F || i_baud_double) // [R7]
		else $error("slow fixed rate ticks too often");
	shift_pin_a: assert property (s.m0_busy && !s.m0_rx |-> !o_rx_data_pin_oe_n) // [R15]
		else $error("shift data pin not driven");
	// Asynchronous 8-bit transmit reaching its stop bit
	uart8_tx_c: cover property (set_ti && mode == serial_port_uart_pkg::MODE_UART8);
endmodule : serial_port_uart

// File: tb/serial_peer.sv
// Serial peer model: sends asynchronous frames and feeds the shift-register receiver
`timescale 1ns/1ns
module serial_peer (
	// Core clock
	input  wire logic        i_mclk,
	// Asynchronous frame request
	input  wire logic        i_go,
	input  wire logic [10:0] i_frame,
	input  wire logic [3:0]  i_nbits,
	input  wire logic [9:0]  i_bitlen,
	// Shift-register request and device shift clock
	input  wire logic        i_m0_go,
	input  wire logic        i_sclk,
	// Line toward the device, pulled up when released
	output logic             o_line
);
	initial begin
		o_line = 1'b1;
	end
	// Frame bits held a whole bit time each, start bit first, LSB first
	always @(posedge i_go) begin
		for (int i = 0; i < i_nbits; i++) begin
			o_line <= i_frame[i];
			repeat (i_bitlen) @(posedge i_mclk);
		end
		o_line <= 1'b1;
	end
	// Next bit after each rising shift clock, so the low phase sees a settled bit
	always @(posedge i_m0_go) begin
		o_line <= i_frame[0];
		for (int i = 1; i < 9; i++) begin
			@(posedge i_sclk);
			o_line <= (i < 8) ? i_frame[i] : 1'b1;
		end
	end
endmodule : serial_peer

// File: tb/serial_port_uart_tb.sv
// Self-checking bench for the serial port with a serial peer model
`timescale 1ns/1ns
module serial_port_uart_tb;
	logic                           i_mclk, i_rst_n, i_baud_double, i_baud_clk, tick, go, m0_go;
	serial_port_uart_pkg::sfr_req_t i_sfr;
	logic [7:0]                     o_sfr_rdata, d, d2, rd, base;
	logic                           o_rx_data_pin, o_rx_data_pin_oe_n, o_tx_pin, peer_line, rx_wire, n9;
	logic [10:0]                    frame, got;
	logic [3:0]                     nbits;
	logic [9:0]                     bitlen;
	int                             fails, cmp_count, bl;
	time                            t0;
	// Wire level of the shared data pin
	assign rx_wire = o_rx_data_pin_oe_n ? peer_line : o_rx_data_pin;
	serial_port_uart serial_port_uart_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr(i_sfr),
		.o_sfr_rdata(o_sfr_rdata), .i_baud_double(i_baud_double), .i_baud_clk(i_baud_clk),
		.i_tx_baud_tick(tick), .i_rx_baud_tick(tick), .i_rx_data_pin(rx_wire),
		.o_rx_data_pin(o_rx_data_pin), .o_rx_data_pin_oe_n(o_rx_data_pin_oe_n), .o_tx_pin(o_tx_pin));
	serial_peer serial_peer_inst (.i_mclk(i_mclk), .i_go(go), .i_frame(frame), .i_nbits(nbits),
		.i_bitlen(bitlen), .i_m0_go(m0_go), .i_sclk(o_tx_pin), .o_line(peer_line));
	// Core clock and unrelated baud clock
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	initial begin
		i_baud_clk = 1'b0;
		#3;
		forever #40 i_baud_clk = ~i_baud_clk;
	end
	// One tick every second baud cycle: 16 ticks give a 256-cycle bit
	always @(posedge i_baud_clk) begin
		tick <= ~tick;
	end
	task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Register access: one strobe cycle, data taken one cycle later
	task automatic reg_acc(input logic [7:0] a, input logic w, input logic [7:0] wd);
		i_sfr <= '{addr: a, wr: w, rd: ~w, wdata: wd};
		@(posedge i_mclk);
		i_sfr <= '0;
		@(posedge i_mclk);
		rd = o_sfr_rdata;
	endtask : reg_acc
	task automatic send(input logic [10:0] f, input int n, input int b);
		frame <= f;
		nbits <= 4'(n);
		bitlen <= 10'(b);
		go <= 1'b1;
		@(posedge i_mclk);
		go <= 1'b0;
	endtask : send
	// Capture a transmitted frame by sampling mid-bit
	task automatic cap(input int nb, input int b, output logic [10:0] v);
		v = '0;
		while (o_tx_pin !== 1'b0) @(posedge i_mclk);
		repeat (b / 2) @(posedge i_mclk);
		for (int i = 0; i < nb; i++) begin
			v[i] = o_tx_pin;
			repeat (b) @(posedge i_mclk);
		end
	endtask : cap
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (40000) @(posedge i_mclk);
		fails++;
		conclude();
	end
	initial begin
		{i_rst_n, i_baud_double, tick, go, m0_go, frame, nbits, bitlen, fails, cmp_count} = '0;
		i_sfr = '0;
		void'($urandom(1439));
		// Baud side clears its toggles on the baud edges that follow release
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		reg_acc(8'h98, 1'b0, 8'h00);
		chk(rd, 8'h00);
		reg_acc(8'h99, 1'b0, 8'h00);
		chk(rd, 8'h00);
		reg_acc(8'h9A, 1'b0, 8'h00);
		chk(rd, 8'h00);
		$display("reset test done");
		// Mode 2 at both rates, full duplex, ninth-bit filtering
		for (int bd = 0; bd < 2; bd++) begin
			i_baud_double <= bd[0];
			bl = bd ? 16 : 32;
			n9 = 1'($urandom);
			base = {2'b10, 2'b11, n9, 3'b000};
			reg_acc(8'h98, 1'b1, base);
			for (int k = 0; k < 2; k++) begin
				d = 8'($urandom);
				d2 = 8'($urandom);
				fork
					send({1'b1, k[0], d, 1'b0}, 11, bl);
					reg_acc(8'h99, 1'b1, d2);
					cap(11, bl, got);
				join
				chk(got, {1'b1, n9, d2, 1'b0});
				repeat (2 * bl) @(posedge i_mclk);
				reg_acc(8'h98, 1'b0, 8'h00);
				chk(rd, base | (k ? 8'h07 : 8'h02));
				reg_acc(8'h99, 1'b0, 8'h00);
				if (k) chk(rd, d);
				reg_acc(8'h98, 1'b1, base);
			end
		end
		$display("mode 2 test done");
		// Mode 1 on baud ticks, stop bit checked under multiproc_enable
		for (int s = 0; s < 2; s++) begin
			reg_acc(8'h98, 1'b1, 8'h70);
			d = 8'($urandom);
			d2 = 8'($urandom);
			fork
				send({s[0], d, 1'b0}, 10, 256);
				reg_acc(8'h99, 1'b1, d2);
				cap(10, 256, got);
			join
			chk(got, {1'b1, d2, 1'b0});
			repeat (512) @(posedge i_mclk);
			reg_acc(8'h98, 1'b0, 8'h00);
			chk(rd, s ? 8'h77 : 8'h72);
		end
		reg_acc(8'h99, 1'b0, 8'h00);
		chk(rd, d);
		$display("mode 1 test done");
		// Receiver disabled: frame ignored
		reg_acc(8'h98, 1'b1, 8'h80);
		send({2'b11, 8'($urandom), 1'b0}, 11, 16);
		repeat (300) @(posedge i_mclk);
		reg_acc(8'h98, 1'b0, 8'h00);
		chk(rd, 8'h80);
		// Mode 0 transmit: eight bits LSB first, two-cycle shift clock
		d2 = 8'($urandom);
		reg_acc(8'h98, 1'b1, 8'h00);
		reg_acc(8'h99, 1'b1, d2);
		for (int i = 0; i < 8; i++) begin
			@(posedge o_tx_pin);
			if (i == 0) t0 = $time;
			if (i == 1) chk(11'($time - t0), 11'd20);
			got[i] = rx_wire;
		end
		chk(got[7:0], d2);
		repeat (4) @(posedge i_mclk);
		reg_acc(8'h98, 1'b0, 8'h00);
		chk(rd, 8'h02);
		// Mode 0 receive, then blocked while rx_done_flag stays set
		d = 8'($urandom);
		frame <= {3'b000, d};
		m0_go <= 1'b1;
		@(posedge i_mclk);
		m0_go <= 1'b0;
		reg_acc(8'h98, 1'b1, 8'h10);
		repeat (30) @(posedge i_mclk);
		reg_acc(8'h98, 1'b0, 8'h00);
		chk(rd, 8'h11);
		reg_acc(8'h99, 1'b0, 8'h00);
		chk(rd, d);
		repeat (30) @(posedge i_mclk);
		chk(o_tx_pin, 1'b1);
		reg_acc(8'h99, 1'b0, 8'h00);
		chk(rd, d);
		$display("mode 0 test done");
		conclude();
	end
endmodule : serial_port_uart_tb
